/* dv/dbx_exc_unit_asserts.sv */
// Port-level assertions for the debug exception unit.
`default_nettype none
module dbx_exc_chk (
  input wire logic mclk, // Core clock.
  input wire logic rst, // Synchronous reset.
  input wire logic reg_rd, // Read strobe.
  input wire logic [31:0] reg_rdata, // Read data.
  input wire logic insn_start, // Instruction start.
  input wire logic insn_dr_move, // Debug register move.
  input wire logic insn_done, // Instruction done.
  input wire logic other_exc, // Other exception delivered.
  input wire logic other_exc_fault, // It is fault class.
  input wire logic ext_irq, // External interrupt.
  input wire logic rf_load, // Resume flag load.
  input wire logic rf_image, // Value loaded.
  input wire logic irq_take, // Interrupt accepted.
  input wire logic db_fault, // Debug fault.
  input wire logic db_trap, // Debug trap.
  input wire logic handler_entry, // Handler entered.
  input wire logic pushed_rf, // Pushed resume flag.
  input wire logic clear_step, // Step flag clear.
  input wire logic resume_flag // Live resume flag.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------------------
  // Debug exception timing
  // ---------------------------------------------------------------------------
  // A debug entry is a handler entry that also drops the step flag.
  sequence s_dbg_entry;
    handler_entry && clear_step;
  endsequence
  sequence s_push_one;
    handler_entry && pushed_rf;
  endsequence
  property p_fault_cause;
    db_fault |-> $past(insn_start);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without start");
  property p_trap_cause;
    db_trap |-> $past(insn_done);
  endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("trap without done");
  property p_dbg_entry;
    (db_fault || db_trap) |-> s_dbg_entry;
  endproperty
  a_dbg_entry: assert property (p_dbg_entry) else $error("debug entry incomplete");
  property p_fault_push;
    (other_exc && other_exc_fault) |=> s_push_one;
  endproperty
  a_fault_push: assert property (p_fault_push) else $error("fault push wrong");
  property p_irq_order;
    irq_take |-> (ext_irq && insn_done) ##1 (handler_entry && !db_trap);
  endproperty
  a_irq_order: assert property (p_irq_order) else $error("interrupt beat trap");
  // ---------------------------------------------------------------------------
  // Resume flag and read data
  // ---------------------------------------------------------------------------
  // Only the guard fault may still fire while the flag masks the address match.
  property p_rf_mask;
    (insn_start && resume_flag && !insn_dr_move) |=> !db_fault;
  endproperty
  a_rf_mask: assert property (p_rf_mask) else $error("masked breakpoint fired");
  property p_rf_clear;
    (insn_start && !rf_load) |=> !resume_flag;
  endproperty
  a_rf_clear: assert property (p_rf_clear) else $error("resume flag kept");
  property p_rf_load;
    (rf_load && !insn_start) |=> resume_flag == $past(rf_image);
  endproperty
  a_rf_load: assert property (p_rf_load) else $error("resume flag not loaded");
  // Read data is zero outside its single cycle, so a stale word never leaks.
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule : dbx_exc_chk
bind dbx_exc_unit dbx_exc_chk u_chk (.mclk, .rst, .reg_rd, .reg_rdata, .insn_start,
  .insn_dr_move, .insn_done, .other_exc, .other_exc_fault, .ext_irq, .rf_load, .rf_image,
  .irq_take, .db_fault, .db_trap, .handler_entry, .pushed_rf, .clear_step, .resume_flag);
`default_nettype wire

/* dv/tb.sv */
// Self-checking testbench of the debug exception unit.
`include "dbx_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Every driven input, applied together right after a rising edge.
  typedef struct packed {
    logic chk;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, insn_addr, mem_addr, io_addr;
    logic reg_wr, reg_rd, insn_start, insn_ss_load, insn_dr_move, insn_sw_int;
    logic single_step_flag, insn_done, mem_valid, mem_wr, io_valid, buslock_seen;
    logic [1:0] current_privilege;
    logic rep_nonfinal, fast_mid, task_trap_entry, other_exc, other_exc_fault;
    logic ext_irq, rf_load, rf_image;
  } dbx_tb_in_t;
  localparam logic [36:0] M_ALL = 37'h1F_FFFF_FFFF; // Every observed bit.
  localparam logic [36:0] M_Q = 37'h1D_FFFF_FFFF; // Pushed flag left out.
  localparam logic [36:0] M_RD = 37'h1C_FFFF_FFFF; // Flag levels left out.
  logic mclk = 1'b0;
  logic rst = 1'b1;
  dbx_tb_in_t cur = '0;
  dbx_tb_in_t nxt = '0;
  logic [31:0] reg_rdata;
  logic irq_take, db_fault, db_trap, handler_entry, pushed_rf, clear_step, resume_flag;
  logic chk_d = 1'b0;
  logic [36:0] qv[$];
  logic [36:0] qm[$];
  logic [31:0] seed = 32'h0000_5319;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  // Free running core clock.
  always #5 mclk = ~mclk;
  dbx_exc_unit #(.AW(32)) dut (
    .mclk, .rst, .reg_addr(cur.reg_addr), .reg_wdata(cur.reg_wdata), .reg_wr(cur.reg_wr),
    .reg_rd(cur.reg_rd), .reg_rdata, .insn_start(cur.insn_start), .insn_addr(cur.insn_addr),
    .insn_ss_load(cur.insn_ss_load), .insn_dr_move(cur.insn_dr_move),
    .insn_sw_int(cur.insn_sw_int), .single_step_flag(cur.single_step_flag),
    .current_privilege(cur.current_privilege), .insn_done(cur.insn_done),
    .mem_valid(cur.mem_valid), .mem_addr(cur.mem_addr), .mem_wr(cur.mem_wr),
    .io_valid(cur.io_valid), .io_addr(cur.io_addr), .buslock_seen(cur.buslock_seen),
    .rep_nonfinal(cur.rep_nonfinal), .fast_mid(cur.fast_mid),
    .task_trap_entry(cur.task_trap_entry), .other_exc(cur.other_exc),
    .other_exc_fault(cur.other_exc_fault), .ext_irq(cur.ext_irq), .rf_load(cur.rf_load),
    .rf_image(cur.rf_image), .irq_take, .db_fault, .db_trap, .handler_entry, .pushed_rf,
    .clear_step, .resume_flag
  );
  // Random addresses keep the top bit set so they never meet a breakpoint.
  function automatic logic [31:0] rnd_addr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {1'b1, seed[30:0]};
  endfunction : rnd_addr
  // Apply the staged inputs at the next edge and note what must follow.
  task automatic step(input logic c, input logic [36:0] ev, input logic [36:0] em);
    @(posedge mclk);
    nxt.chk = c;
    if (c) begin
      qv.push_back(ev);
      qm.push_back(em);
    end
    cur <= nxt;
    nxt = '0;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    nxt.reg_addr = a;
    nxt.reg_wdata = d;
    nxt.reg_wr = 1'b1;
    step(1'b0, '0, '0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    nxt.reg_addr = a;
    nxt.reg_rd = 1'b1;
    step(1'b1, {5'h00, d}, M_RD);
  endtask : rd
  // Outcome codes: fault, trap, entry, pushed flag, live flag; pushed flag unchecked idle.
  task automatic start(input logic [31:0] a, input logic c, input logic [4:0] ev);
    nxt.insn_start = 1'b1;
    nxt.insn_addr = a;
    step(c, {ev, 32'h0}, ev[2] ? M_ALL : M_Q);
  endtask : start
  task automatic done(input logic c, input logic [4:0] ev);
    nxt.insn_done = 1'b1;
    step(c, {ev, 32'h0}, ev[2] ? M_ALL : M_Q);
  endtask : done
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // The monitor compares the cycle after each noted request.
  always @(posedge mclk) chk_d <= cur.chk;
  always @(negedge mclk) begin
    logic [36:0] got, ev, em;
    if (chk_d) begin
      ev = qv.pop_front();
      em = qm.pop_front();
      got = {db_fault, db_trap, handler_entry, pushed_rf, resume_flag, reg_rdata};
      check_count++;
      if ((got & em) !== (ev & em)) begin
        error_cnt++;
        $display("[ERR] t=%0t got %h exp %h", $time, got & em, ev & em);
      end
    end
  end
  // A hang ends the run as a mismatch; the tests need about 60 cycles.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] r;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(`DBX_OFS_CTRL, 32'h0);
    rd(`DBX_OFS_STAT, 32'h0);
    rd(8'h1C, 32'h0);
    r = rnd_addr();
    wr(`DBX_OFS_BP2, r);
    rd(`DBX_OFS_BP2, r);
    wr(`DBX_OFS_BP0, 32'h100);
    wr(`DBX_OFS_BP1, 32'h400);
    wr(`DBX_OFS_BP3, 32'h60);
    wr(`DBX_OFS_CTRL, 32'h2010_0045);
    rd(`DBX_OFS_CTRL, 32'h2010_0045);
    $display("test registers done");
    start(32'h100, 1'b1, 5'h14);
    wr(`DBX_OFS_STAT, 32'h0);
    nxt.rf_load = 1'b1;
    nxt.rf_image = 1'b1;
    step(1'b1, {5'h01, 32'h0}, M_Q);
    start(32'h100, 1'b1, 5'h00);
    done(1'b0, 5'h00);
    nxt.insn_ss_load = 1'b1;
    start(rnd_addr(), 1'b0, 5'h00);
    nxt.insn_ss_load = 1'b1;
    {nxt.mem_valid, nxt.mem_wr, nxt.mem_addr} = {2'h3, 32'h400};
    done(1'b1, 5'h00);
    start(32'h100, 1'b1, 5'h00);
    done(1'b1, 5'h0C);
    $display("test resume and stack load done");
    wr(`DBX_OFS_STAT, 32'h0);
    start(rnd_addr(), 1'b0, 5'h00);
    {nxt.mem_valid, nxt.mem_wr, nxt.mem_addr} = {2'h2, 32'h400};
    done(1'b1, 5'h00);
    start(rnd_addr(), 1'b0, 5'h00);
    {nxt.mem_valid, nxt.mem_wr, nxt.mem_addr} = {2'h3, 32'h400};
    done(1'b1, 5'h0C);
    rd(`DBX_OFS_STAT, 32'h2);
    start(rnd_addr(), 1'b0, 5'h00);
    {nxt.io_valid, nxt.io_addr} = {1'b1, 32'h60};
    done(1'b1, 5'h0C);
    nxt.insn_ss_load = 1'b1;
    start(rnd_addr(), 1'b0, 5'h00);
    nxt.insn_ss_load = 1'b1;
    {nxt.mem_valid, nxt.mem_wr, nxt.mem_addr} = {2'h3, 32'h400};
    done(1'b0, 5'h00);
    start(rnd_addr(), 1'b0, 5'h00);
    {nxt.other_exc, nxt.other_exc_fault} = 2'h3;
    step(1'b1, {5'h06, 32'h0}, M_ALL);
    start(rnd_addr(), 1'b0, 5'h00);
    done(1'b1, 5'h00);
    $display("test data and discard done");
    wr(`DBX_OFS_CTRL, 32'h2010_2045);
    wr(`DBX_OFS_STAT, 32'h0);
    nxt.insn_dr_move = 1'b1;
    start(rnd_addr(), 1'b1, 5'h16);
    rd(`DBX_OFS_STAT, 32'h2000);
    wr(`DBX_OFS_CTRL, 32'h2010_0045);
    wr(`DBX_OFS_STAT, 32'h0);
    nxt.single_step_flag = 1'b1;
    start(rnd_addr(), 1'b0, 5'h00);
    nxt.ext_irq = 1'b1;
    done(1'b1, 5'h0C);
    rd(`DBX_OFS_STAT, 32'h4000);
    wr(`DBX_OFS_STAT, 32'h0);
    start(rnd_addr(), 1'b0, 5'h00);
    nxt.ext_irq = 1'b1;
    done(1'b1, 5'h04);
    start(rnd_addr(), 1'b0, 5'h00);
    nxt.task_trap_entry = 1'b1;
    done(1'b1, 5'h0C);
    rd(`DBX_OFS_STAT, 32'h8000);
    $display("test guard step and task done");
    wr(`DBX_OFS_DBGCTL, 32'h4);
    start(rnd_addr(), 1'b0, 5'h00);
    {nxt.current_privilege, nxt.buslock_seen} = 3'h7;
    done(1'b1, 5'h0C);
    start(rnd_addr(), 1'b0, 5'h00);
    {nxt.current_privilege, nxt.buslock_seen} = 3'h1;
    done(1'b1, 5'h00);
    $display("test bus lock done");
    repeat (3) step(1'b0, '0, '0);
    end_sim();
  end
endmodule : tb
`default_nettype wire

/* hdl/dbx_bp_match.sv */
// Address comparators for the four breakpoint address registers.
`default_nettype none
module dbx_bp_match #(
  parameter int AW = 32
) (
  dbx_bp_if.match bp // Configuration in, hit vectors out.
);
  // Length code to ignored low address bits: 1, 2, 8 or 4 bytes.
  function automatic logic [AW-1:0] len_mask(input logic [1:0] len);
    logic [AW-1:0] m;
    m = '0;
    unique case (len)
      2'h0: m[2:0] = 3'h0;
      2'h1: m[2:0] = 3'h1;
      2'h2: m[2:0] = 3'h7;
      2'h3: m[2:0] = 3'h3;
    endcase
    return m;
  endfunction : len_mask

  function automatic logic addr_hit(input logic [AW-1:0] a, input logic [AW-1:0] b,
    input logic [1:0] len);
    return ((a ^ b) & ~len_mask(len)) == '0;
  endfunction : addr_hit

  // -----------------------------------------------------------------------------
  // Per-register compare
  // -----------------------------------------------------------------------------
  // Only the start address of an access is compared; a split access that only
  // reaches a watched region with its tail bytes is not seen.
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      bp.hit_exec[n] = bp.bp_en[n] && bp.bp_type[n] == dbx_pkg::BP_EXEC &&
        bp.exec_addr == bp.bp_addr[n];
      bp.hit_data[n] = bp.bp_en[n] && bp.mem_valid &&
        addr_hit(bp.mem_addr, bp.bp_addr[n], bp.bp_len[n]) &&
        ((bp.bp_type[n] == dbx_pkg::BP_WRITE && bp.mem_wr) ||
         bp.bp_type[n] == dbx_pkg::BP_RDWR);
      bp.hit_io[n] = bp.bp_en[n] && bp.io_valid && bp.bp_type[n] == dbx_pkg::BP_IO &&
        addr_hit(bp.io_addr, bp.bp_addr[n], bp.bp_len[n]);
    end
  end
endmodule : dbx_bp_match
`default_nettype wire

/* hdl/dbx_exc_unit.sv */
// Debug exception detection, resume flag handling and debug register file.
`include "dbx_params.svh"
`default_nettype none
// Overview of operation
// - Enabled execute breakpoint matching next instruction raises a fault before it runs.
// - Instruction breakpoint outranks every other exception of the same instruction.
// - Instruction breakpoint right after a stack segment load is suppressed.
// - Resume flag masks instruction breakpoints only, for one instruction.
// - Resume flag clears at instruction start, after the breakpoint check.
// - Task switch and interrupt return load resume flag; flags pop does not.
// - Other fault-class handler entries push resume flag as one.
// - Interrupt or trap after non-final string iteration pushes resume flag as one.
// - Data and I/O breakpoint types trap after the accessing instruction.
// - Fast-string data breakpoint may wait for the end of its group.
// - Repeated string I/O traps after its iteration; memory after matching one.
// - Stack segment load data breakpoint is delivered after the next instruction.
// - Delivering any exception other than a software interrupt discards pending data and I/O breakpoints.
// - Software interrupts keep pending data breakpoints; trap follows handler entry.
// - Guard bit set: debug register move faults first and sets guard hit.
// - Single step traps after each instruction, not the one setting the flag.
// - Debug handler entry and software interrupts clear the single step flag.
// - Single step trap goes before a coinciding external interrupt.
// - Stack segment load under single step gives no step trap.
// - Switch into a trapped task raises debug exception and task hit flag.
// - Bus lock at privilege above zero traps when enabled; delivery clears flag.
// - Type field: 0 execute, 1 write, 2 I/O, 3 read or write.
module dbx_exc_unit #(
  parameter int AW = 32
) (
  input wire logic mclk, // Core clock, 100 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, cycle after the read strobe.
  input wire logic insn_start, // Instruction about to execute.
  input wire logic [AW-1:0] insn_addr, // Its address.
  input wire logic insn_ss_load, // It loads the stack segment.
  input wire logic insn_dr_move, // It moves to or from a debug register.
  input wire logic insn_sw_int, // It is a software interrupt.
  input wire logic single_step_flag, // Live single step flag.
  input wire logic [1:0] current_privilege, // Current privilege level.
  input wire logic insn_done, // Instruction or iteration completed.
  input wire logic mem_valid, // A data access was made.
  input wire logic [AW-1:0] mem_addr, // Its address.
  input wire logic mem_wr, // It was a write.
  input wire logic io_valid, // An I/O access was made.
  input wire logic [AW-1:0] io_addr, // Its port address.
  input wire logic buslock_seen, // The instruction asserted a bus lock.
  input wire logic rep_nonfinal, // Completed iteration was not the last.
  input wire logic fast_mid, // Fast-string group still running.
  input wire logic task_trap_entry, // Entered a task with its trap bit set.
  input wire logic other_exc, // A non-debug exception is being delivered.
  input wire logic other_exc_fault, // That exception is fault-class.
  input wire logic ext_irq, // External interrupt pending.
  input wire logic rf_load, // Task switch or interrupt return loads flags.
  input wire logic rf_image, // Resume flag in the saved image.
  output logic irq_take, // External interrupt accepted at this boundary.
  output logic db_fault, // Fault-class debug exception, one cycle.
  output logic db_trap, // Trap-class debug exception, one cycle.
  output logic handler_entry, // Any handler entered, one cycle.
  output logic pushed_rf, // Resume flag value for the pushed image.
  output logic clear_step, // Clear the single step flag, one cycle.
  output logic resume_flag // Live resume flag.
);
  // -----------------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------------
  logic [AW-1:0] bp_addr_ff [4];
  logic [31:0] ctrl_ff;
  logic [31:0] stat_ff;
  logic [31:0] dbgctl_ff;
  logic [31:0] rdata_ff;
  logic rf_ff;
  logic ss_shadow_ff;
  logic step_arm_ff;
  logic [3:0] pend_hit_ff;
  logic pend_ff;
  logic pend_hold_ff;
  logic db_fault_ff;
  logic db_trap_ff;
  logic entry_ff;
  logic pushed_rf_ff;
  logic clear_step_ff;

  dbx_bp_if #(.AW(AW)) bp ();

  dbx_bp_match #(.AW(AW)) u_match (
    .bp(bp)
  );

  // Field extraction used by the interface drive; the read mux returns whole words.
  function automatic logic [1:0] ctrl_field(input logic [31:0] w, input int lsb);
    return w[lsb +: 2];
  endfunction : ctrl_field

  // -----------------------------------------------------------------------------
  // Comparator configuration
  // -----------------------------------------------------------------------------
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      bp.bp_addr[n] = bp_addr_ff[n];
      bp.bp_type[n] = dbx_pkg::dbx_bp_type_t'(ctrl_field(ctrl_ff,
        `DBX_CTRL_TYPE_LSB + `DBX_CTRL_STRIDE * n));
      bp.bp_len[n] = ctrl_field(ctrl_ff, `DBX_CTRL_LEN_LSB + `DBX_CTRL_STRIDE * n);
      bp.bp_en[n] = |ctrl_field(ctrl_ff, 2 * n);
    end
  end

  assign bp.exec_addr = insn_addr;
  assign bp.mem_addr = mem_addr;
  assign bp.mem_valid = mem_valid && insn_done;
  assign bp.mem_wr = mem_wr;
  assign bp.io_addr = io_addr;
  assign bp.io_valid = io_valid && insn_done;

  // -----------------------------------------------------------------------------
  // Start-of-instruction checks
  // -----------------------------------------------------------------------------
  logic ibp_hit;
  logic guard_hit;
  // The resume flag and the load shadow mask only execute breakpoints.
  assign ibp_hit = insn_start && (|bp.hit_exec) && !rf_ff && !ss_shadow_ff;
  assign guard_hit = insn_start && insn_dr_move && ctrl_ff[`DBX_CTRL_GUARD];

  // -----------------------------------------------------------------------------
  // Completion checks
  // -----------------------------------------------------------------------------
  logic data_now;
  logic step_trap;
  logic lock_trap;
  logic pend_ready;
  logic trap_fire;
  logic lose_pend;

  assign data_now = |(bp.hit_data | bp.hit_io);
  // Step arming is sampled at start, so an instruction that sets the flag never traps.
  assign step_trap = insn_done && step_arm_ff && !rep_nonfinal;
  assign lock_trap = insn_done && buslock_seen && dbgctl_ff[`DBX_DBGCTL_BLD] &&
    current_privilege != 2'h0;
  // Pending breakpoints wait out the load shadow and a running fast-string group.
  assign pend_ready = insn_done && (pend_ff || data_now) && !insn_ss_load &&
    !fast_mid;
  // Any other exception loses pending hits; a software interrupt is not one.
  assign lose_pend = other_exc && !insn_sw_int;
  assign trap_fire = !lose_pend && (pend_ready || step_trap || lock_trap ||
    (insn_done && task_trap_entry));

  // Single step trap is taken first; the interrupt is looked at again next boundary.
  assign irq_take = ext_irq && insn_done && !trap_fire && !db_trap_ff;

  // -----------------------------------------------------------------------------
  // Resume flag, load shadow and step arming
  // -----------------------------------------------------------------------------
  // Cleared at start after the breakpoint check; only task switch and interrupt
  // return may load it, the flags pop path has no way in.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rf_ff <= 1'b0;
    end else if (rf_load) begin
      rf_ff <= rf_image;
    end else if (insn_start) begin
      rf_ff <= 1'b0;
    end
  end

  // Stack segment load shadow covers exactly the following instruction.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ss_shadow_ff <= 1'b0;
    end else if (insn_done) begin
      ss_shadow_ff <= insn_ss_load;
    end
  end

  // Single step arming taken at start; a stack segment load never arms it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      step_arm_ff <= 1'b0;
    end else if (insn_start) begin
      step_arm_ff <= single_step_flag && !insn_ss_load && !ss_shadow_ff;
    end else if (insn_done && !rep_nonfinal) begin
      step_arm_ff <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------------
  // Pending data and I/O breakpoints
  // -----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_ff <= 1'b0;
      pend_hold_ff <= 1'b0;
      pend_hit_ff <= 4'h0;
    end else if (lose_pend || (ibp_hit || guard_hit)) begin
      pend_ff <= 1'b0;
      pend_hold_ff <= 1'b0;
      pend_hit_ff <= 4'h0;
    end else if (trap_fire) begin
      pend_ff <= 1'b0;
      pend_hold_ff <= 1'b0;
      pend_hit_ff <= 4'h0;
    end else if (insn_done && data_now) begin
      pend_ff <= 1'b1;
      pend_hold_ff <= insn_ss_load;
      pend_hit_ff <= pend_hit_ff | bp.hit_data | bp.hit_io;
    end
  end

  // -----------------------------------------------------------------------------
  // Exception outputs
  // -----------------------------------------------------------------------------
  // Execute breakpoint and guard faults are raised before any other exception
  // of the same instruction is allowed to surface.
  always_ff @(posedge mclk) begin
    if (rst) begin
      db_fault_ff <= 1'b0;
      db_trap_ff <= 1'b0;
    end else begin
      db_fault_ff <= ibp_hit || guard_hit;
      db_trap_ff <= trap_fire && !(ibp_hit || guard_hit);
    end
  end

  // Pushed resume flag value for every handler entry.
  always_ff @(posedge mclk) begin
    if (rst) begin
      entry_ff <= 1'b0;
      pushed_rf_ff <= 1'b0;
    end else if (ibp_hit) begin
      entry_ff <= 1'b1;
      pushed_rf_ff <= rf_ff;
    end else if (guard_hit || (other_exc && other_exc_fault)) begin
      entry_ff <= 1'b1;
      pushed_rf_ff <= 1'b1;
    end else if (trap_fire || irq_take || other_exc) begin
      entry_ff <= 1'b1;
      pushed_rf_ff <= rep_nonfinal ? 1'b1 : rf_ff;
    end else begin
      entry_ff <= 1'b0;
    end
  end

  // Single step is dropped on debug handler entry and by software interrupts.
  always_ff @(posedge mclk) begin
    if (rst) begin
      clear_step_ff <= 1'b0;
    end else begin
      clear_step_ff <= ibp_hit || guard_hit || trap_fire ||
        (insn_done && insn_sw_int);
    end
  end

  assign db_fault = db_fault_ff;
  assign db_trap = db_trap_ff;
  assign handler_entry = entry_ff;
  assign pushed_rf = pushed_rf_ff;
  assign clear_step = clear_step_ff;
  assign resume_flag = rf_ff;

  // -----------------------------------------------------------------------------
  // Register file
  // -----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int n = 0; n < 4; n++) begin
        bp_addr_ff[n] <= '0;
      end
    end else if (reg_wr) begin
      for (int n = 0; n < 4; n++) begin
        if (reg_addr == `DBX_OFS_BP0 + 8'(4 * n)) begin
          bp_addr_ff[n] <= reg_wdata[AW-1:0];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_ff <= `DBX_RST_WORD;
      dbgctl_ff <= `DBX_RST_WORD;
    end else if (reg_wr) begin
      if (reg_addr == `DBX_OFS_CTRL) begin
        ctrl_ff <= reg_wdata;
      end
      if (reg_addr == `DBX_OFS_DBGCTL) begin
        dbgctl_ff <= reg_wdata;
      end
    end
  end

  // Status: software writes store, hardware sets win over a same-cycle write.
  logic [31:0] nxt_stat;
  always_comb begin
    nxt_stat = stat_ff;
    if (reg_wr && reg_addr == `DBX_OFS_STAT) begin
      nxt_stat = reg_wdata;
    end
    if (trap_fire || ibp_hit) begin
      nxt_stat[3:0] = pend_hit_ff | bp.hit_data | bp.hit_io | bp.hit_exec;
    end
    if (guard_hit) begin
      nxt_stat[`DBX_STAT_GUARD] = 1'b1;
    end
    if (step_trap && !lose_pend) begin
      nxt_stat[`DBX_STAT_STEP] = 1'b1;
    end
    if (insn_done && task_trap_entry && !lose_pend) begin
      nxt_stat[`DBX_STAT_TASK] = 1'b1;
    end
    if (lock_trap && !lose_pend) begin
      nxt_stat[`DBX_STAT_BUSLOCK] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_ff <= `DBX_RST_WORD;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // Read data stands for the one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `DBX_OFS_BP0: rdata_ff <= 32'(bp_addr_ff[0]);
        `DBX_OFS_BP1: rdata_ff <= 32'(bp_addr_ff[1]);
        `DBX_OFS_BP2: rdata_ff <= 32'(bp_addr_ff[2]);
        `DBX_OFS_BP3: rdata_ff <= 32'(bp_addr_ff[3]);
        `DBX_OFS_CTRL: rdata_ff <= ctrl_ff;
        `DBX_OFS_STAT: rdata_ff <= stat_ff;
        `DBX_OFS_DBGCTL: rdata_ff <= dbgctl_ff;
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule : dbx_exc_unit
`default_nettype wire

/* pkg/dbx_bp_if.sv */
// Breakpoint configuration and hit vectors between unit and comparator.
`default_nettype none
interface dbx_bp_if #(parameter int AW = 32);
  logic [AW-1:0] bp_addr [4];
  dbx_pkg::dbx_bp_type_t bp_type [4];
  logic [1:0] bp_len [4];
  logic [3:0] bp_en;
  logic [AW-1:0] exec_addr;
  logic [AW-1:0] mem_addr;
  logic mem_valid;
  logic mem_wr;
  logic [AW-1:0] io_addr;
  logic io_valid;
  logic [3:0] hit_exec;
  logic [3:0] hit_data;
  logic [3:0] hit_io;
  modport unit (output bp_addr, bp_type, bp_len, bp_en, exec_addr, mem_addr, mem_valid,
    mem_wr, io_addr, io_valid, input hit_exec, hit_data, hit_io);
  modport match (input bp_addr, bp_type, bp_len, bp_en, exec_addr, mem_addr, mem_valid,
    mem_wr, io_addr, io_valid, output hit_exec, hit_data, hit_io);
endinterface : dbx_bp_if
`default_nettype wire

/* pkg/dbx_params.svh */
// Register offsets, field positions and reset values of the debug exception unit.
`ifndef DBX_PARAMS_SVH
`define DBX_PARAMS_SVH
// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define DBX_OFS_BP0 8'h00
`define DBX_OFS_BP1 8'h04
`define DBX_OFS_BP2 8'h08
`define DBX_OFS_BP3 8'h0C
`define DBX_OFS_CTRL 8'h10
`define DBX_OFS_STAT 8'h14
`define DBX_OFS_DBGCTL 8'h18
// -----------------------------------------------------------------------------
// Control word fields
// -----------------------------------------------------------------------------
`define DBX_CTRL_GUARD 13
`define DBX_CTRL_TYPE_LSB 16
`define DBX_CTRL_LEN_LSB 18
`define DBX_CTRL_STRIDE 4
// -----------------------------------------------------------------------------
// Status word fields and debug control bits
// -----------------------------------------------------------------------------
`define DBX_STAT_BUSLOCK 11
`define DBX_STAT_GUARD 13
`define DBX_STAT_STEP 14
`define DBX_STAT_TASK 15
`define DBX_DBGCTL_BLD 2
`define DBX_RST_WORD 32'h0000_0000
`endif

/* pkg/dbx_pkg.sv */
// Types shared by the debug exception unit.
`default_nettype none
package dbx_pkg;
  // Breakpoint type field encoding.
  typedef enum logic [1:0] {
    BP_EXEC  = 2'h0,
    BP_WRITE = 2'h1,
    BP_IO    = 2'h2,
    BP_RDWR  = 2'h3
  } dbx_bp_type_t;
endpackage : dbx_pkg
`default_nettype wire
